// File: psc_chk_asserts.sv
// Port checker for the PWM output stage control
`timescale 1ns/1ps
module psc_chk (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [3:0] pwm_o,
	input wire logic [3:0] channel_active_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// A read that collides with a write is left out of the checks
	wire logic rd = reg_rd_i && !reg_wr_i;
	////////////////////////////////////////////////////////////////
	dly_rsvd_a: assert property (rd && reg_addr_i inside {[8'h11:8'h14]}
		|=> reg_rdata_o[1:0] == 2'b00) else $error("delay low bits not zero");
	dly_write_a: assert property (reg_wr_i && reg_addr_i == 8'h11 ##1 !reg_wr_i
		##1 rd && reg_addr_i == 8'h11
		|=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'hFC)) else $error("delay readback wrong");
	grp_fixed_a: assert property (rd && reg_addr_i == 8'h19
		|=> reg_rdata_o[7:4] == 4'h3) else $error("group fixed bits wrong");
	period_rsvd_a: assert property (rd && reg_addr_i == 8'h1A
		|=> reg_rdata_o[6:5] == 2'b00) else $error("period reserved bits set");
	limit_rsvd_a: assert property (rd && reg_addr_i == 8'h10
		|=> reg_rdata_o[7:3] == 5'h00) else $error("limit reserved bits set");
	sys_bits_a: assert property (rd && reg_addr_i == 8'h05
		|=> (reg_rdata_o & 8'h9F) == 8'h00) else $error("system bits beyond D6 D5");
	rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without read");
	stopped_low_a: assert property (channel_active_o == 4'h0 && $past(channel_active_o) == 4'h0
		|-> pwm_o == 4'h0) else $error("stopped channel drives");
endmodule // psc_chk
bind psc_output_ctrl psc_chk u_chk (.mclk_i, .resetn_i, .reg_wr_i, .reg_rd_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pwm_o, .channel_active_o);

// File: psc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_ADDR_SYS_CTRL 8'h05
`define PSC_ADDR_LIMIT 8'h10
`define PSC_ADDR_DLY_CH1 8'h11
`define PSC_ADDR_DLY_CH2 8'h12
`define PSC_ADDR_DLY_CH1_INV 8'h13
`define PSC_ADDR_DLY_CH2_INV 8'h14
`define PSC_ADDR_STOP_GROUP 8'h19
`define PSC_ADDR_SOFT_PERIOD 8'h1A

`define PSC_SYS_SHUTDOWN_BIT 6
`define PSC_SYS_GROUP_OFF_BIT 5
`define PSC_SOFT_DISABLE_BIT 7
`define PSC_DLY_MSB 7
`define PSC_DLY_LSB 2

`define PSC_RST_SYS_CTRL 8'h40
`define PSC_RST_LIMIT 8'h02
`define PSC_RST_DLY_CH1 8'hAC
`define PSC_RST_DLY_CH2 8'h54
`define PSC_RST_STOP_GROUP 8'h30
`define PSC_RST_SOFT_PERIOD 8'h0F
`define PSC_GROUP_FIXED_ONES 8'h30

`define PSC_CLK_PERIOD_NS 40
`define PSC_TICK_NS 100000
`define PSC_TICK_CYCLES (`PSC_TICK_NS / `PSC_CLK_PERIOD_NS)
`define PSC_DELAY_STEP_CYCLES 4

`endif

// File: psc_output_ctrl.sv
// Top of the PWM output stage control: registers, shutdown sequencing, four channels
//
// Summary of operation
// - Duty is capped per 3-bit limit code, 99.2% at 000 down to 93.8%.
// - Each channel is delayed by programmed value times four modulator clocks.
// - Delay is signed six bits in 7:2, -32 to +31; low bits reserved.
// - Channels 1, 2, 1 inverted, 2 inverted use delay registers 0x11 to 0x14.
// - Delay registers reset to 0xAC for channel 1 pair, 0x54 for channel 2.
// - Stop-group mask bits 3:0 select channels 4 to 1 into the group.
// - On shutdown exit with system bit D5 zero, group channels stay stopped.
// - Shutdown entry, exit or power-down pin change runs a 50% duty period.
// - Period code with upper bits 00 gives no 50% duty period.
// - Codes 01000 to 11111 select 16.5 ms to 13196.4 ms; default 01111.
// - Start and stop periods are approximate.
// - System bit D6 set enters shutdown; clear exits and starts playback.
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_output_ctrl #(
	parameter int W = 8,
	parameter int TICK_CYCLES = `PSC_TICK_CYCLES
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic power_down_pin_n_i,
	input wire logic [W-1:0] duty_ch1_i,
	input wire logic [W-1:0] duty_ch2_i,
	output logic [3:0] pwm_o,
	output logic [3:0] channel_active_o,
	output logic soft_busy_o
);
	import psc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Period table in units of 0.1 ms; tick length is a parameter so runs can shrink it
	function automatic logic [17:0] period_units(input logic [4:0] code);
		logic [17:0] u;
		u = 18'h00000;
		unique case (code[4:0])
			5'h08: u = 18'd165;
			5'h09: u = 18'd239;
			5'h0A: u = 18'd314;
			5'h0B: u = 18'd404;
			5'h0C: u = 18'd539;
			5'h0D: u = 18'd703;
			5'h0E: u = 18'd942;
			5'h0F: u = 18'd1257;
			5'h10: u = 18'd1646;
			5'h11: u = 18'd2394;
			5'h12: u = 18'd3142;
			5'h13: u = 18'd4039;
			5'h14: u = 18'd5386;
			5'h15: u = 18'd7031;
			5'h16: u = 18'd9425;
			5'h17: u = 18'd12566;
			5'h18: u = 18'd17281;
			5'h19: u = 18'd25136;
			5'h1A: u = 18'd32991;
			5'h1B: u = 18'd42417;
			5'h1C: u = 18'd56556;
			5'h1D: u = 18'd73837;
			5'h1E: u = 18'd98973;
			5'h1F: u = 18'd131964;
			default: u = 18'h00000;
		endcase
		return u;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [1:0] sys_reg, sys_next;
	logic [2:0] limit_reg, limit_next;
	psc_delay_t dly_reg [4];
	psc_delay_t dly_next [4];
	logic [3:0] group_reg, group_next;
	logic soft_dis_reg, soft_dis_next;
	logic [4:0] soft_code_reg, soft_code_next;
	logic [7:0] rdata_next;
	// Reset images as typed constants, so their fields can be sliced
	localparam logic [7:0] RST_SYS = `PSC_RST_SYS_CTRL;
	localparam logic [7:0] RST_LIMIT = `PSC_RST_LIMIT;
	localparam logic [7:0] RST_DLY_CH1 = `PSC_RST_DLY_CH1;
	localparam logic [7:0] RST_DLY_CH2 = `PSC_RST_DLY_CH2;
	localparam logic [7:0] RST_GROUP = `PSC_RST_STOP_GROUP;
	localparam logic [7:0] RST_SOFT = `PSC_RST_SOFT_PERIOD;

	always_comb begin
		sys_next = sys_reg;
		limit_next = limit_reg;
		dly_next = dly_reg;
		group_next = group_reg;
		soft_dis_next = soft_dis_reg;
		soft_code_next = soft_code_reg;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`PSC_ADDR_SYS_CTRL: sys_next = {reg_wdata_i[`PSC_SYS_SHUTDOWN_BIT],
					reg_wdata_i[`PSC_SYS_GROUP_OFF_BIT]};
				`PSC_ADDR_LIMIT: limit_next = reg_wdata_i[2:0];
				`PSC_ADDR_DLY_CH1: dly_next[0] = reg_wdata_i[`PSC_DLY_MSB:`PSC_DLY_LSB];
				`PSC_ADDR_DLY_CH2: dly_next[1] = reg_wdata_i[`PSC_DLY_MSB:`PSC_DLY_LSB];
				`PSC_ADDR_DLY_CH1_INV: dly_next[2] = reg_wdata_i[`PSC_DLY_MSB:`PSC_DLY_LSB];
				`PSC_ADDR_DLY_CH2_INV: dly_next[3] = reg_wdata_i[`PSC_DLY_MSB:`PSC_DLY_LSB];
				`PSC_ADDR_STOP_GROUP: group_next = reg_wdata_i[3:0];
				`PSC_ADDR_SOFT_PERIOD: begin
					soft_dis_next = reg_wdata_i[`PSC_SOFT_DISABLE_BIT];
					soft_code_next = reg_wdata_i[4:0];
				end
				default: ;
			endcase
		end
		// Reserved bits read back at their fixed values, whatever the host wrote
		rdata_next = 8'h00;
		unique case (reg_addr_i)
			`PSC_ADDR_SYS_CTRL: rdata_next = {1'b0, sys_reg, 5'h00};
			`PSC_ADDR_LIMIT: rdata_next = {5'h00, limit_reg};
			`PSC_ADDR_DLY_CH1: rdata_next = {dly_reg[0], 2'b00};
			`PSC_ADDR_DLY_CH2: rdata_next = {dly_reg[1], 2'b00};
			`PSC_ADDR_DLY_CH1_INV: rdata_next = {dly_reg[2], 2'b00};
			`PSC_ADDR_DLY_CH2_INV: rdata_next = {dly_reg[3], 2'b00};
			`PSC_ADDR_STOP_GROUP: rdata_next = `PSC_GROUP_FIXED_ONES | {4'h0, group_reg};
			`PSC_ADDR_SOFT_PERIOD: rdata_next = {soft_dis_reg, 2'b00, soft_code_reg};
			default: rdata_next = 8'h00;
		endcase
		if (!reg_rd_i) begin
			rdata_next = reg_rdata_o;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			sys_reg <= {RST_SYS[`PSC_SYS_SHUTDOWN_BIT],
				RST_SYS[`PSC_SYS_GROUP_OFF_BIT]};
			limit_reg <= RST_LIMIT[2:0];
			dly_reg[0] <= RST_DLY_CH1[`PSC_DLY_MSB:`PSC_DLY_LSB];
			dly_reg[1] <= RST_DLY_CH2[`PSC_DLY_MSB:`PSC_DLY_LSB];
			dly_reg[2] <= RST_DLY_CH1[`PSC_DLY_MSB:`PSC_DLY_LSB];
			dly_reg[3] <= RST_DLY_CH2[`PSC_DLY_MSB:`PSC_DLY_LSB];
			group_reg <= RST_GROUP[3:0];
			soft_dis_reg <= RST_SOFT[`PSC_SOFT_DISABLE_BIT];
			soft_code_reg <= RST_SOFT[4:0];
			reg_rdata_o <= 8'h00;
		end else begin
			sys_reg <= sys_next;
			limit_reg <= limit_next;
			dly_reg <= dly_next;
			group_reg <= group_next;
			soft_dis_reg <= soft_dis_next;
			soft_code_reg <= soft_code_next;
			reg_rdata_o <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-down pin synchroniser
	logic pdn_meta_reg, pdn_sync_reg;

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pdn_meta_reg <= 1'b0;
			pdn_sync_reg <= 1'b0;
		end else begin
			pdn_meta_reg <= power_down_pin_n_i;
			pdn_sync_reg <= pdn_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shutdown sequencing and soft start/stop timer
	psc_state_t state_reg, state_next;
	logic [31:0] tick_reg, tick_next;
	logic [17:0] units_reg, units_next;
	logic [3:0] hold_reg, hold_next;
	logic [W-1:0] count_reg, count_next;
	logic [3:0] active_next;
	logic want_run;
	logic timer_on;
	logic done;

	always_comb begin
		want_run = !sys_reg[1] && pdn_sync_reg;
		// A disabled timer or a code of 00xxx skips the 50% period entirely
		timer_on = !soft_dis_reg && (soft_code_reg[4:3] != 2'b00);
		done = (units_reg == 18'h00000);
		state_next = state_reg;
		hold_next = hold_reg;
		tick_next = tick_reg;
		units_next = units_reg;
		if (!done) begin
			if (tick_reg >= 32'(TICK_CYCLES - 1)) begin
				tick_next = 32'h00000000;
				units_next = units_reg - 18'h00001;
			end else begin
				tick_next = tick_reg + 32'h00000001;
			end
		end
		unique case (state_reg)
			PSC_ST_OFF: begin
				if (want_run) begin
					hold_next = sys_reg[0] ? 4'h0 : group_reg;
					state_next = timer_on ? PSC_ST_START : PSC_ST_RUN;
					tick_next = 32'h00000000;
					units_next = period_units(soft_code_reg);
				end
			end
			PSC_ST_START: begin
				if (!want_run) begin
					state_next = PSC_ST_STOP;
					tick_next = 32'h00000000;
					units_next = period_units(soft_code_reg);
				end else if (done) begin
					state_next = PSC_ST_RUN;
				end
			end
			PSC_ST_RUN: begin
				if (!want_run) begin
					state_next = timer_on ? PSC_ST_STOP : PSC_ST_OFF;
					tick_next = 32'h00000000;
					units_next = period_units(soft_code_reg);
				end
			end
			PSC_ST_STOP: begin
				if (want_run) begin
					state_next = PSC_ST_START;
					tick_next = 32'h00000000;
					units_next = period_units(soft_code_reg);
				end else if (done) begin
					state_next = PSC_ST_OFF;
				end
			end
		endcase
		active_next = (state_next == PSC_ST_OFF) ? 4'h0 : ~hold_next;
		count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			state_reg <= PSC_ST_OFF;
			tick_reg <= 32'h00000000;
			units_reg <= 18'h00000;
			hold_reg <= 4'h0;
			count_reg <= '0;
			channel_active_o <= 4'h0;
			soft_busy_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			tick_reg <= tick_next;
			units_reg <= units_next;
			hold_reg <= hold_next;
			count_reg <= count_next;
			channel_active_o <= active_next;
			soft_busy_o <= (state_next == PSC_ST_START) || (state_next == PSC_ST_STOP);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channels: 1, 2, 1 inverted, 2 inverted
	logic [W-1:0] limit_cnt;
	logic [W-1:0] duty_sel [4];
	logic half_duty;

	always_comb begin
		// Cap of 254/256 less two counts per code step, about 0.8% each
		limit_cnt = W'({1'b1, {(W-1){1'b0}}} * 2 - 2) - W'({limit_reg, 1'b0});
		duty_sel[0] = duty_ch1_i;
		duty_sel[1] = duty_ch2_i;
		duty_sel[2] = ~duty_ch1_i;
		duty_sel[3] = ~duty_ch2_i;
		half_duty = (state_reg == PSC_ST_START) || (state_reg == PSC_ST_STOP);
	end

	for (genvar i = 0; i < 4; i++) begin : g_chan
		psc_pwm_channel #(
			.W(W)
		) u_chan (
			.mclk_i(mclk_i),
			.resetn_i(resetn_i),
			.count_i(count_reg),
			.delay_i(dly_reg[i]),
			.duty_i(duty_sel[i]),
			.limit_i(limit_cnt),
			.half_i(half_duty),
			.run_i(channel_active_o[i]),
			.pwm_o(pwm_o[i])
		);
	end
endmodule // psc_output_ctrl

// File: psc_pkg.sv
// Types shared by the PWM output stage control block
package psc_pkg;
	typedef enum logic [1:0] {
		PSC_ST_OFF,
		PSC_ST_START,
		PSC_ST_RUN,
		PSC_ST_STOP
	} psc_state_t;
	typedef logic [5:0] psc_delay_t;
endpackage

// File: psc_power_stage.sv
// Power stage model: high cycles of each PWM line per 256-cycle period
`timescale 1ns/1ps
module psc_power_stage (
	input wire logic mclk_i,
	input wire logic [3:0] pwm_i,
	output logic [3:0][8:0] high_o
);
	logic [7:0] win_reg = 8'h00;
	logic [7:0] win_next;
	logic [3:0][8:0] acc_reg = '0;
	logic [3:0][8:0] acc_next;
	logic [3:0][8:0] high_next;
	////////////////////////////////////////////////////////////////
	// Integrating over a whole period makes carrier phase irrelevant
	always_comb begin
		win_next = win_reg + 8'h01;
		for (int i = 0; i < 4; i++) begin
			acc_next[i] = (win_reg == 8'h00 ? 9'h000 : acc_reg[i]) + {8'h00, pwm_i[i]};
			high_next[i] = win_reg == 8'h00 ? acc_reg[i] : high_o[i];
		end
	end
	always_ff @(posedge mclk_i) begin
		win_reg <= win_next;
		acc_reg <= acc_next;
		high_o <= high_next;
	end
endmodule // psc_power_stage

// File: psc_pwm_channel.sv
// One PWM channel: delayed carrier phase, duty clamp, 50% override
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_pwm_channel #(
	parameter int W = 8
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] count_i,
	input wire psc_pkg::psc_delay_t delay_i,
	input wire logic [W-1:0] duty_i,
	input wire logic [W-1:0] limit_i,
	input wire logic half_i,
	input wire logic run_i,
	output logic pwm_o
);
	import psc_pkg::*;

	localparam logic [W-1:0] HALF = {1'b1, {(W-1){1'b0}}};

	logic [W-1:0] shift;
	logic [W-1:0] phase;
	logic [W-1:0] duty_eff;
	logic pwm_next;

	always_comb begin
		// Delay is value times four modulator clocks, signed, wraps on the carrier
		shift = W'($signed({delay_i, 2'b00}));
		phase = count_i - shift;
		if (half_i) begin
			duty_eff = HALF;
		end else if (duty_i > limit_i) begin
			duty_eff = limit_i;
		end else begin
			duty_eff = duty_i;
		end
		pwm_next = run_i && (phase < duty_eff);
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pwm_o <= 1'b0;
		end else begin
			pwm_o <= pwm_next;
		end
	end
endmodule // psc_pwm_channel

// File: psc_tb.sv
// Testbench for the PWM output stage control
`timescale 1ns/1ps
module testbench;
	logic mclk_i = 0, rstn = 0, wr = 0, rd = 0, pin = 1, busy;
	logic [7:0] addr = 8'h00, wdat = 8'h00, d1 = 8'h00, d2 = 8'h00, rdat;
	logic [3:0] pwm, act;
	logic [3:0][8:0] hi;
	int err_count = 0, num_checks = 0, cyc = 0;
	always #20 mclk_i = ~mclk_i;
	psc_output_ctrl #(.W(8), .TICK_CYCLES(4)) uut (.mclk_i(mclk_i), .resetn_i(rstn),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdat),
		.reg_rdata_o(rdat), .power_down_pin_n_i(pin), .duty_ch1_i(d1), .duty_ch2_i(d2),
		.pwm_o(pwm), .channel_active_o(act), .soft_busy_o(busy));
	psc_power_stage ps (.mclk_i(mclk_i), .pwm_i(pwm), .high_o(hi));
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wreg(logic [7:0] a, logic [7:0] d);
		@(posedge mclk_i);
		wr <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask
	task automatic rreg(logic [7:0] a, logic [7:0] e);
		@(posedge mclk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1 chk("reg", {8'h00, rdat}, {8'h00, e});
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [15:0] t[10] = '{16'h0540, 16'h1002, 16'h11AC, 16'h1254, 16'h13AC,
			16'h1454, 16'h1930, 16'h1A0F, 16'h1500, 16'h1F00};
		logic [7:0] v[4] = '{8'hB8, 8'h60, 8'hA0, 8'h48};
		foreach (t[i]) rreg(t[i][15:8], t[i][7:0]);
		foreach (v[i]) wreg(8'h11 + 8'(i), v[i]);
		foreach (v[i]) rreg(8'h11 + 8'(i), v[i]);
		wreg(8'h11, 8'h54);
		rreg(8'h11, 8'h54);
		wreg(8'h11, 8'hB8);
	endtask
	task automatic t_limit();
		wreg(8'h1A, 8'h80);
		wreg(8'h05, 8'h00);
		repeat (4) @(posedge mclk_i);
		chk("run", act, 4'hF);
		chk("nobusy", busy, 1'b0);
		d1 <= 8'hFF;
		for (int c = 0; c < 8; c++) begin
			wreg(8'h10, 8'(c));
			repeat (600) @(posedge mclk_i);
			chk("cap", hi[0], 16'(254 - 2 * c));
		end
	endtask
	task automatic t_delay();
		int n = 0;
		d1 <= 8'h80;
		d2 <= 8'h80;
		wreg(8'h11, 8'h00);
		wreg(8'h12, 8'h04);
		repeat (300) @(posedge mclk_i);
		@(posedge pwm[0]);
		do begin
			@(posedge mclk_i);
			#1 n++;
		end while (!pwm[1] && n < 300);
		chk("skew", 16'(n), 16'h0004);
	endtask
	task automatic t_group();
		wreg(8'h05, 8'h40);
		repeat (4) @(posedge mclk_i);
		chk("off", act, 4'h0);
		wreg(8'h19, 8'h3A);
		wreg(8'h05, 8'h00);
		repeat (4) @(posedge mclk_i);
		chk("grp", act, 4'h5);
		wreg(8'h05, 8'h40);
		wreg(8'h05, 8'h20);
		repeat (4) @(posedge mclk_i);
		chk("nogrp", act, 4'hF);
		wreg(8'h05, 8'h40);
		wreg(8'h19, 8'h30);
	endtask
	task automatic t_soft();
		int n = 0;
		wreg(8'h1A, 8'h08);
		wreg(8'h05, 8'h00);
		for (int k = 0; k < 800; k++) begin
			@(posedge mclk_i);
			#1 n += busy;
			if (k == 600) chk("half", hi[0], 16'h0080);
		end
		chk("len", n >= 660 && n <= 662, 1'b1);
		wreg(8'h05, 8'h40);
		repeat (800) @(posedge mclk_i);
		wreg(8'h1A, 8'h00);
		wreg(8'h05, 8'h00);
		n = 0;
		repeat (20) begin
			@(posedge mclk_i);
			#1 n += busy;
		end
		chk("none", 16'(n), 16'h0000);
		wreg(8'h1A, 8'h08);
		pin <= 1'b0;
		repeat (6) @(posedge mclk_i);
		chk("pin", busy, 1'b1);
	endtask
	initial begin
		repeat (20) @(posedge mclk_i);
		rstn <= 1'b1;
		t_regs();
		t_limit();
		t_delay();
		t_group();
		t_soft();
		give_verdict();
	end
endmodule // testbench
